/* verilog/gpio_port_bit_config.sv */
// general-purpose i/o port with per-pin mode, atomic set/clear and lock
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - speed field zero means input; 01, 10, 11 pick output slew
// - config field picks push-pull/open-drain/alternate, or analog/floating/pulled
// - reset leaves alternates off and every pin except the debug pins a floating input
// - debug pins come up as pulled inputs, up or down per pin
// - pulled input: output bit 1 pulls up, 0 pulls down
// - general output drives the pin from its output data bit
// - open-drain: 0 pulls low, 1 releases; high side never driven
// - push-pull: 0 drives low, 1 drives high
// - input data samples every pin every cycle in all modes except analog input
// - output and alternate modes keep pull resistors off
// - input mode disables driver, keeps receiver active except in analog mode
// - output data reads last written value; input data reads pin level
// - set/clear writes change only selected output bits in one access
// - alternate output drives pin from peripheral signal, not output data
// - alternate output with idle peripheral may show any level
// - bidirectional alternate keeps the input path active as floating
// - after lock sequence a pin's configuration is frozen until reset
// - remap settings move peripheral functions onto alternative pins
// - analog input: driver, receiver, pulls off; input data reads 0
module gpio_port_bit_config #(
    parameter int unsigned ADDR_W = 8,
    parameter logic [15:0] DEBUG_PULL_UP_MASK = 16'ha000,
    parameter logic [15:0] DEBUG_PULL_DOWN_MASK = 16'h4000
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire gpio_port_pkg::word_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output gpio_port_pkg::word_t reg_rdata,
    input wire gpio_port_pkg::pin_vec_t pin_in,
    output gpio_port_pkg::pin_vec_t pin_out,
    output gpio_port_pkg::pin_vec_t pin_oe_n,
    output gpio_port_pkg::pin_vec_t pin_pull_up,
    output gpio_port_pkg::pin_vec_t pin_pull_down,
    output gpio_port_pkg::pin_vec_t pin_rx_enable,
    input wire gpio_port_pkg::pin_vec_t af_out,
    input wire gpio_port_pkg::pin_vec_t af_out_remap,
    output gpio_port_pkg::pin_vec_t peripheral_input_function,
    output gpio_port_pkg::pin_vec_t remap_select
);
    import gpio_port_pkg::*;

    initial begin
        if (ADDR_W < 8) begin
            $error("ADDR_W must be at least 8");
        end
        if ((DEBUG_PULL_UP_MASK & DEBUG_PULL_DOWN_MASK) != 16'h0000) begin
            $error("a debug pin cannot be pulled both up and down");
        end
    end

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic pin_field_t field_of(input logic [CFG_W-1:0] cfg, input int unsigned pin);
        field_of = cfg[pin*FIELD_W +: FIELD_W];
    endfunction : field_of

    // reset image of all fields: debug pins pulled, the rest floating
    function automatic logic [CFG_W-1:0] reset_fields(input pin_vec_t pulled);
        logic [CFG_W-1:0] r;
        r = '0;
        for (int unsigned i = 0; i < PIN_COUNT; i++) begin
            r[i*FIELD_W +: FIELD_W] = pulled[i] ? FIELD_PULLED : FIELD_RESET;
        end
        reset_fields = r;
    endfunction : reset_fields

    // write 8 fields into half of the image, skipping locked pins
    function automatic logic [CFG_W-1:0] merge_half(input logic [CFG_W-1:0] cfg,
                                                   input word_t data, input logic high,
                                                   input pin_vec_t locked);
        logic [CFG_W-1:0] r;
        int unsigned p;
        r = cfg;
        for (int unsigned i = 0; i < PIN_COUNT / 2; i++) begin
            p = high ? i + PIN_COUNT / 2 : i;
            if (!locked[p]) begin
                r[p*FIELD_W +: FIELD_W] = data[i*FIELD_W +: FIELD_W];
            end
        end
        merge_half = r;
    endfunction : merge_half

    localparam pin_vec_t DEBUG_PULLED = DEBUG_PULL_UP_MASK | DEBUG_PULL_DOWN_MASK;
    localparam logic [CFG_W-1:0] CFG_RESET_IMAGE = reset_fields(DEBUG_PULLED);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        LOCK_IDLE = 2'b00,
        LOCK_FIRST_ONE = 2'b01,
        LOCK_ZERO = 2'b10
    } lock_state_e;

    logic [CFG_W-1:0] cfg_q;
    pin_vec_t odr_q;
    pin_vec_t idr_q;
    pin_vec_t locked_q;
    logic lock_key_q;
    pin_vec_t lock_bits_q;
    lock_state_e lock_state_q;
    pin_vec_t remap_q;
    pin_vec_t pin_meta_q;
    pin_vec_t pin_sync_q;
    word_t rdata_q;
    pin_vec_t pin_out_q;
    pin_vec_t pin_oe_n_q;
    pin_vec_t pull_up_q;
    pin_vec_t pull_down_q;
    pin_vec_t rx_en_q;

    logic [7:0] word_addr;
    logic wr_cfg_low;
    logic wr_cfg_high;
    logic wr_odr;
    logic wr_set_clear;
    logic wr_clear;
    logic wr_lock;
    logic wr_remap;
    logic rd_lock;

    assign word_addr = reg_addr[7:0];
    assign wr_cfg_low = reg_wr && (word_addr == OFS_PORT_CONFIG_LOW);
    assign wr_cfg_high = reg_wr && (word_addr == OFS_PORT_CONFIG_HIGH);
    assign wr_odr = reg_wr && (word_addr == OFS_PORT_OUTPUT_DATA);
    assign wr_set_clear = reg_wr && (word_addr == OFS_PORT_BIT_SET_CLEAR);
    assign wr_clear = reg_wr && (word_addr == OFS_PORT_BIT_CLEAR);
    assign wr_lock = reg_wr && (word_addr == OFS_PORT_CONFIG_LOCK);
    assign wr_remap = reg_wr && (word_addr == OFS_PORT_REMAP);
    assign rd_lock = reg_rd && (word_addr == OFS_PORT_CONFIG_LOCK);

    // ------------------------------------------------------------------
    // per-pin mode decode
    // ------------------------------------------------------------------
    pin_vec_t in_mask;
    pin_vec_t analog_mask;
    pin_vec_t pulled_mask;
    pin_vec_t af_mask;
    pin_vec_t od_mask;
    pin_vec_t drive_val;

    always_comb begin
        pin_field_t f;
        logic [1:0] pin_config_field;
        f = '0;
        pin_config_field = '0;
        for (int unsigned i = 0; i < PIN_COUNT; i++) begin
            f = field_of(cfg_q, i);
            pin_config_field = f[CONFIG_LSB +: 2];
            in_mask[i] = f[SPEED_LSB +: 2] == SPEED_INPUT;
            analog_mask[i] = in_mask[i] && (pin_config_field == CFG_IN_ANALOG);
            pulled_mask[i] = in_mask[i] && (pin_config_field == CFG_IN_PULLED);
            af_mask[i] = !in_mask[i] && pin_config_field[1];
            od_mask[i] = !in_mask[i] && pin_config_field[0];
            // alternate source follows the remap choice
            drive_val[i] = af_mask[i] ? (remap_q[i] ? af_out_remap[i] : af_out[i]) : odr_q[i];
        end
    end

    // ------------------------------------------------------------------
    // pin input synchroniser and input data sampling
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        pin_meta_q <= pin_in;
        pin_sync_q <= pin_meta_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            idr_q <= '0;
        end else begin
            idr_q <= pin_sync_q & ~analog_mask;
        end
    end

    // ------------------------------------------------------------------
    // pad control outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            pin_out_q <= '0;
            pin_oe_n_q <= '1;
            pull_up_q <= '0;
            pull_down_q <= '0;
            rx_en_q <= '0;
        end else begin
            for (int unsigned i = 0; i < PIN_COUNT; i++) begin
                if (in_mask[i]) begin
                    pin_oe_n_q[i] <= 1'b1;
                    pin_out_q[i] <= 1'b0;
                    pull_up_q[i] <= pulled_mask[i] && odr_q[i];
                    pull_down_q[i] <= pulled_mask[i] && !odr_q[i];
                    rx_en_q[i] <= !analog_mask[i];
                end else begin
                    pull_up_q[i] <= 1'b0;
                    pull_down_q[i] <= 1'b0;
                    rx_en_q[i] <= 1'b1;
                    if (od_mask[i]) begin
                        pin_out_q[i] <= 1'b0;
                        pin_oe_n_q[i] <= drive_val[i];
                    end else begin
                        pin_out_q[i] <= drive_val[i];
                        pin_oe_n_q[i] <= 1'b0;
                    end
                end
            end
        end
    end

    // rx_en is low during reset and on analog input pins; other pins are released after the first cycle
    assign pin_out = pin_out_q;
    assign pin_oe_n = pin_oe_n_q;
    assign pin_pull_up = pull_up_q;
    assign pin_pull_down = pull_down_q;
    assign pin_rx_enable = rx_en_q;
    assign peripheral_input_function = idr_q;
    assign remap_select = remap_q;

    // ------------------------------------------------------------------
    // configuration with per-pin lock
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            cfg_q <= CFG_RESET_IMAGE;
        end else if (wr_cfg_low) begin
            cfg_q <= merge_half(cfg_q, reg_wdata, 1'b0, locked_q);
        end else if (wr_cfg_high) begin
            cfg_q <= merge_half(cfg_q, reg_wdata, 1'b1, locked_q);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            remap_q <= '0;
        end else if (wr_remap) begin
            remap_q <= reg_wdata[PIN_COUNT-1:0];
        end
    end

    // ------------------------------------------------------------------
    // output data with atomic set and clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            odr_q <= DEBUG_PULL_UP_MASK;
        end else if (wr_odr) begin
            odr_q <= reg_wdata[PIN_COUNT-1:0];
        end else if (wr_set_clear) begin
            // set applied after clear so set wins
            odr_q <= (odr_q & ~reg_wdata[CLEAR_SHIFT +: PIN_COUNT]) | reg_wdata[PIN_COUNT-1:0];
        end else if (wr_clear) begin
            odr_q <= odr_q & ~reg_wdata[PIN_COUNT-1:0];
        end
    end

    // ------------------------------------------------------------------
    // lock sequence: write key 1, key 0, key 1 with the same pin bits
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            lock_state_q <= LOCK_IDLE;
            lock_bits_q <= '0;
            locked_q <= '0;
            lock_key_q <= 1'b0;
        end else if (wr_lock) begin
            unique case (lock_state_q)
                LOCK_IDLE: begin
                    lock_bits_q <= reg_wdata[PIN_COUNT-1:0];
                    lock_state_q <= reg_wdata[LOCK_KEY_BIT] ? LOCK_FIRST_ONE : LOCK_IDLE;
                end
                LOCK_FIRST_ONE: begin
                    if (!reg_wdata[LOCK_KEY_BIT] && reg_wdata[PIN_COUNT-1:0] == lock_bits_q) begin
                        lock_state_q <= LOCK_ZERO;
                    end else begin
                        lock_bits_q <= reg_wdata[PIN_COUNT-1:0];
                        lock_state_q <= reg_wdata[LOCK_KEY_BIT] ? LOCK_FIRST_ONE : LOCK_IDLE;
                    end
                end
                LOCK_ZERO: begin
                    if (reg_wdata[LOCK_KEY_BIT] && reg_wdata[PIN_COUNT-1:0] == lock_bits_q) begin
                        locked_q <= locked_q | lock_bits_q;
                        lock_key_q <= 1'b1;
                    end
                    lock_state_q <= LOCK_IDLE;
                end
                default: begin
                    lock_state_q <= LOCK_IDLE;
                end
            endcase
        end else if (rd_lock) begin
            lock_state_q <= LOCK_IDLE;
        end
    end

    // ------------------------------------------------------------------
    // read data, one cycle after the read strobe
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            unique case (word_addr)
                OFS_PORT_CONFIG_LOW: rdata_q <= cfg_q[DATA_W-1:0];
                OFS_PORT_CONFIG_HIGH: rdata_q <= cfg_q[CFG_W-1:DATA_W];
                OFS_PORT_INPUT_DATA: rdata_q <= {16'h0000, idr_q};
                OFS_PORT_OUTPUT_DATA: rdata_q <= {16'h0000, odr_q};
                OFS_PORT_CONFIG_LOCK: rdata_q <= {15'h0000, lock_key_q, locked_q};
                OFS_PORT_REMAP: rdata_q <= {16'h0000, remap_q};
                default: rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    a_reset_floating: assert property (@(posedge clk)
        srst |=> (cfg_q == CFG_RESET_IMAGE) && (locked_q == '0) && (odr_q == DEBUG_PULL_UP_MASK))
        else $error("configuration not at reset image after reset");

    a_idr_samples_pin: assert property (@(posedge clk) disable iff (srst)
        !$past(srst) |-> idr_q == ($past(pin_sync_q) & ~$past(analog_mask)))
        else $error("input data does not follow the pin");

    a_analog_reads_zero: assert property (@(posedge clk) disable iff (srst)
        ##1 ((analog_mask & ~$past(analog_mask) & idr_q) == '0)
            |-> ((($past(analog_mask) & idr_q) == '0) && (($past(analog_mask) & rx_en_q) == '0)))
        else $error("analog pin shows data or an active receiver");

    a_od_no_high: assert property (@(posedge clk) disable iff (srst)
        ##1 ($past(od_mask) & ~pin_oe_n & pin_out) == '0)
        else $error("open-drain pin driven high");

    a_pp_follows_odr: assert property (@(posedge clk) disable iff (srst)
        !srst |=> (($past(~in_mask & ~od_mask & ~af_mask)
                    & (pin_oe_n | (pin_out ^ $past(odr_q)))) == '0))
        else $error("push-pull pin does not show output data");

    a_pull_off_output: assert property (@(posedge clk) disable iff (srst)
        ##1 (($past(~in_mask) & (pin_pull_up | pin_pull_down)) == '0))
        else $error("pull resistor active on an output pin");

    a_input_no_drive: assert property (@(posedge clk) disable iff (srst)
        ##1 (($past(in_mask) & ~pin_oe_n) == '0))
        else $error("input pin is driven");

    a_pull_direction: assert property (@(posedge clk) disable iff (srst)
        !srst |=> ((pin_pull_up == ($past(pulled_mask) & $past(odr_q)))
             && (pin_pull_down == ($past(pulled_mask) & ~$past(odr_q)))))
        else $error("pull direction does not match output data");

    a_set_clear_atomic: assert property (@(posedge clk) disable iff (srst)
        wr_set_clear |=> odr_q == (($past(odr_q) & ~$past(reg_wdata[31:16])) | $past(reg_wdata[15:0])))
        else $error("set/clear write gave wrong output data");

    a_clear_only: assert property (@(posedge clk) disable iff (srst)
        wr_clear |=> odr_q == ($past(odr_q) & ~$past(reg_wdata[15:0])))
        else $error("clear write gave wrong output data");

    a_lock_holds: assert property (@(posedge clk) disable iff (srst)
        (wr_cfg_low || wr_cfg_high) && locked_q[0] |=> field_of(cfg_q, 0) == $past(field_of(cfg_q, 0)))
        else $error("locked pin configuration changed");

    a_read_output_data: assert property (@(posedge clk) disable iff (srst)
        reg_rd && (word_addr == OFS_PORT_OUTPUT_DATA) && !reg_wr
            |=> reg_rdata == {16'h0000, $past(odr_q)})
        else $error("output data read mismatch");

endmodule : gpio_port_bit_config

`default_nettype wire

/* verilog/gpio_port_pkg.sv */
// constants shared by the general-purpose i/o port block
package gpio_port_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int unsigned PIN_COUNT = 16;
    localparam int unsigned FIELD_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned CFG_W = PIN_COUNT * FIELD_W;

    typedef logic [PIN_COUNT-1:0] pin_vec_t;
    typedef logic [FIELD_W-1:0] pin_field_t;
    typedef logic [DATA_W-1:0] word_t;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_PORT_CONFIG_LOW = 8'h00;
    localparam logic [7:0] OFS_PORT_CONFIG_HIGH = 8'h04;
    localparam logic [7:0] OFS_PORT_INPUT_DATA = 8'h08;
    localparam logic [7:0] OFS_PORT_OUTPUT_DATA = 8'h0c;
    localparam logic [7:0] OFS_PORT_BIT_SET_CLEAR = 8'h10;
    localparam logic [7:0] OFS_PORT_BIT_CLEAR = 8'h14;
    localparam logic [7:0] OFS_PORT_CONFIG_LOCK = 8'h18;
    localparam logic [7:0] OFS_PORT_REMAP = 8'h1c;

    // ------------------------------------------------------------------
    // per-pin field layout: speed in low two bits, config field above
    // ------------------------------------------------------------------
    localparam int unsigned SPEED_LSB = 0;
    localparam int unsigned CONFIG_LSB = 2;

    localparam logic [1:0] SPEED_INPUT = 2'h0;
    localparam logic [1:0] SPEED_10MHZ = 2'h1;
    localparam logic [1:0] SPEED_2MHZ = 2'h2;
    localparam logic [1:0] SPEED_50MHZ = 2'h3;

    // output variants
    localparam logic [1:0] CFG_GP_PUSH_PULL = 2'h0;
    localparam logic [1:0] CFG_GP_OPEN_DRAIN = 2'h1;
    localparam logic [1:0] CFG_AF_PUSH_PULL = 2'h2;
    localparam logic [1:0] CFG_AF_OPEN_DRAIN = 2'h3;
    // input variants
    localparam logic [1:0] CFG_IN_ANALOG = 2'h0;
    localparam logic [1:0] CFG_IN_FLOATING = 2'h1;
    localparam logic [1:0] CFG_IN_PULLED = 2'h2;

    // reset nibbles: floating input, and pulled input for debug pins
    localparam pin_field_t FIELD_RESET = 4'h4;
    localparam pin_field_t FIELD_PULLED = 4'h8;

    // ------------------------------------------------------------------
    // bit set/clear and lock layout
    // ------------------------------------------------------------------
    localparam int unsigned CLEAR_SHIFT = 16;
    localparam int unsigned LOCK_KEY_BIT = 16;

endpackage : gpio_port_pkg

/* tb/gpio_pad_model.sv */
// pad and board model for the pins of the i/o port
`timescale 1ns/1ps
`default_nettype none

module gpio_pad_model (
    input wire logic clk,
    input wire gpio_port_pkg::pin_vec_t pin_out,
    input wire gpio_port_pkg::pin_vec_t pin_oe_n,
    input wire gpio_port_pkg::pin_vec_t pin_pull_up,
    input wire gpio_port_pkg::pin_vec_t pin_pull_down,
    input wire gpio_port_pkg::pin_vec_t ext_data,
    input wire gpio_port_pkg::pin_vec_t ext_en,
    output gpio_port_pkg::pin_vec_t pin_level
);
    import gpio_port_pkg::*;

    // --------------------------------------------------------------
    // wire level
    // --------------------------------------------------------------
    pin_vec_t float_q;

    // an undriven, unpulled pin wanders: it shows the inverse of its last level
    always_ff @(posedge clk) begin
        float_q <= ~pin_level;
    end

    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (pin_oe_n[i] == 1'b0) begin
                pin_level[i] = pin_out[i];
            end else if (ext_en[i]) begin
                pin_level[i] = ext_data[i];
            end else if (pin_pull_up[i]) begin
                pin_level[i] = 1'b1;
            end else if (pin_pull_down[i]) begin
                pin_level[i] = 1'b0;
            end else begin
                pin_level[i] = float_q[i];
            end
        end
    end
endmodule : gpio_pad_model

`default_nettype wire

/* tb/gpio_port_bit_config_tb_top.sv */
// self-checking bench for the general-purpose i/o port
`timescale 1ns/1ps
`default_nettype none

module gpio_port_bit_config_tb_top;
    import gpio_port_pkg::*;

    logic clk = 1'b0;
    logic srst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    word_t reg_wdata = '0, reg_rdata, odr, v, exp_q[$];
    pin_vec_t pin_in, pin_out, pin_oe_n, pin_pull_up, pin_pull_down, pin_rx_enable, pif;
    pin_vec_t remap_select, af_out = '0, af_out_remap = '0, ext_data = '0, ext_en = '1;
    int n_mismatch = 0;
    int comparisons = 0;

    gpio_port_bit_config i_dut (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pin_in, .pin_out, .pin_oe_n, .pin_pull_up, .pin_pull_down,
        .pin_rx_enable, .af_out, .af_out_remap, .peripheral_input_function(pif),
        .remap_select);
    gpio_pad_model i_pads (.clk, .pin_out, .pin_oe_n, .pin_pull_up, .pin_pull_down,
        .ext_data, .ext_en, .pin_level(pin_in));

    // --------------------------------------------------------------
    // bus tasks and comparison
    // --------------------------------------------------------------
    task automatic chk(input string nm, input word_t e, input word_t g);
        comparisons++;
        if (g !== e) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input word_t d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input word_t e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    task automatic cfg(input word_t c);
        wr(OFS_PORT_CONFIG_LOW, c);
        wr(OFS_PORT_CONFIG_HIGH, c);
    endtask : cfg

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic end_of_test();
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_of_test

    // --------------------------------------------------------------
    // clock, read-data watcher and hang guard
    // --------------------------------------------------------------
    initial begin
        forever #20 clk = ~clk;
    end

    always @(posedge clk) rd_d <= reg_rd;

    always @(negedge clk) begin
        if (rd_d) begin
            if (exp_q.size() == 0) chk("read without expectation", '0, 32'h1);
            else chk("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        end_of_test();
    end

    // --------------------------------------------------------------
    // scenarios
    // --------------------------------------------------------------
    initial begin
        void'($urandom(12811));
        repeat (6) @(posedge clk);
        srst <= 1'b0;
        settle(2);
        chk("pin_oe_n", 16'hffff, pin_oe_n);
        chk("pin_rx_enable", 16'hffff, pin_rx_enable);
        chk("pin_pull_up", 16'ha000, pin_pull_up);
        chk("pin_pull_down", 16'h4000, pin_pull_down);
        rd(OFS_PORT_CONFIG_LOW, 32'h44444444);
        rd(OFS_PORT_CONFIG_HIGH, 32'h88844444);
        rd(OFS_PORT_OUTPUT_DATA, 32'h0000a000);
        odr = $urandom() & 32'hffff;
        wr(OFS_PORT_OUTPUT_DATA, odr);
        for (int s = 1; s < 4; s++) begin
            cfg({8{2'b00, s[1:0]}});
            settle(2);
            chk("pin_oe_n", 16'h0000, pin_oe_n);
            chk("pin_out", odr, pin_out);
            chk("pulls", '0, pin_pull_up | pin_pull_down);
        end
        rd(OFS_PORT_OUTPUT_DATA, odr);
        for (int i = 0; i < 4; i++) begin
            v = $urandom();
            wr(OFS_PORT_BIT_SET_CLEAR, v);
            odr = (odr & ~(v >> 16)) | (v & 32'hffff);
            rd(OFS_PORT_OUTPUT_DATA, odr);
            wr(OFS_PORT_BIT_CLEAR, v ^ 32'h00005a5a);
            odr = odr & ~((v ^ 32'h00005a5a) & 32'hffff);
            settle(2);
            chk("pin_out", odr, pin_out);
        end
        rd(OFS_PORT_BIT_SET_CLEAR, '0);
        cfg(32'h77777777);
        @(posedge clk);
        ext_data <= 16'($urandom());
        settle(6);
        chk("pin_out", '0, pin_out);
        chk("pin_oe_n", odr, pin_oe_n);
        chk("peripheral_input_function", odr & ext_data, pif);
        rd(OFS_PORT_INPUT_DATA, odr & ext_data);
        cfg(32'hbbbbbbbb);
        wr(OFS_PORT_REMAP, 32'h000000f0);
        @(posedge clk);
        af_out <= 16'($urandom());
        af_out_remap <= 16'($urandom());
        settle(5);
        chk("remap_select", 32'h000000f0, remap_select);
        chk("pin_out", (af_out & 16'hff0f) | (af_out_remap & 16'h00f0), pin_out);
        chk("peripheral_input_function", pin_out, pif);
        chk("pin_rx_enable", 16'hffff, pin_rx_enable);
        chk("pulls", '0, pin_pull_up | pin_pull_down);
        cfg(32'hffffffff);
        settle(3);
        chk("pin_out", '0, pin_out);
        chk("pin_oe_n", (af_out & 16'hff0f) | (af_out_remap & 16'h00f0), pin_oe_n);
        cfg(32'h88888888);
        settle(6);
        chk("peripheral_input_function", ext_data, pif);
        @(posedge clk);
        ext_en <= '0;
        settle(6);
        chk("pin_pull_up", odr, pin_pull_up);
        chk("pin_pull_down", odr ^ 32'h0000ffff, pin_pull_down);
        chk("pin_oe_n", 16'hffff, pin_oe_n);
        chk("pin_rx_enable", 16'hffff, pin_rx_enable);
        rd(OFS_PORT_INPUT_DATA, odr);
        cfg(32'h00000000);
        settle(6);
        chk("pin_rx_enable", '0, pin_rx_enable);
        chk("pulls", '0, pin_pull_up | pin_pull_down);
        rd(OFS_PORT_INPUT_DATA, '0);
        wr(OFS_PORT_CONFIG_LOCK, 32'h000100ff);
        wr(OFS_PORT_CONFIG_LOCK, 32'h000000ff);
        wr(OFS_PORT_CONFIG_LOCK, 32'h000100ff);
        rd(OFS_PORT_CONFIG_LOCK, 32'h000100ff);
        cfg(32'h33333333);
        rd(OFS_PORT_CONFIG_LOW, '0);
        rd(OFS_PORT_CONFIG_HIGH, 32'h33333333);
        rd(8'h20, '0);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        wr(OFS_PORT_CONFIG_LOW, 32'h33333333);
        rd(OFS_PORT_CONFIG_LOW, 32'h33333333);
        settle(2);
        end_of_test();
    end
endmodule : gpio_port_bit_config_tb_top

`default_nettype wire
